// file: logic/nvm_ecc_health.sv
// Contract
// R1 - wafer Y in bits 14:8, bit 15 zero
// R2 - wafer X in bits 6:0, bit 7 zero
// R3 - memory split into trace, identity, config zones
// R4 - no host write path into memory
// R5 - secded: correct single, detect double errors
// R6 - config zone corrected single error sets bit 15
// R7 - config zone double error sets bit 14
// R8 - identity zone corrected single sets bit 13
// R9 - identity zone double error sets bit 12
// R10 - trace zone corrected single sets bit 11
// R11 - trace zone double error sets bit 10
// R12 - read-only revision: major, minor, stage, patch
// R13 - flags found at load, held until reset
`timescale 1ns/10ps
module nvm_ecc_health #(
	parameter logic [3:0] REV_MAJOR = 4'h1,
	parameter logic [3:0] REV_MINOR = 4'h0,
	parameter logic [1:0] REV_STAGE = 2'h3,
	parameter logic [5:0] REV_PATCH = 6'h00
) (
	input  wire logic                                SYS_CLK,
	input  wire logic                                RST_N,
	output logic                                     MEM_RD_EN,
	output logic [config_memory_health_pkg::MEM_AW-1:0]        MEM_ADDR,
	input  wire logic [config_memory_health_pkg::CODE_W-1:0]   MEM_RDATA,
	output logic                                     LOAD_VALID,
	output logic [config_memory_health_pkg::MEM_AW-1:0]        LOAD_ADDR,
	output logic [config_memory_health_pkg::DATA_W-1:0]        LOAD_DATA,
	output logic                                     LOAD_DONE,
	input  wire logic                                REG_RD,
	input  wire logic [4:0]                          REG_MMD,
	input  wire logic [15:0]                         REG_ADDR,
	output logic                                     REG_RVALID,
	output logic [15:0]                              REG_RDATA
);
	import config_memory_health_pkg::*;

	// secded decode: hamming positions 1..21 in bits 1..21, overall parity in bit 0
	function automatic logic [4:0] ham_syndrome(input logic [CODE_W-1:0] cw);
		logic [4:0] s;
		s = 5'h00;
		for (int p = 1; p <= HAM_W; p++) begin
			if (cw[p]) begin
				s = s ^ p[4:0];
			end
		end
		return s;
	endfunction

	function automatic logic [DATA_W-1:0] ham_extract(input logic [CODE_W-1:0] cw);
		logic [DATA_W-1:0] d;
		int                k;
		d = '0;
		k = 0;
		for (int p = 1; p <= HAM_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = cw[p];
				k++;
			end
		end
		return d;
	endfunction

	ld_state_t             ld_state_r, ld_state_nxt;
	logic                  rd_en_r, rd_en_nxt;
	logic [MEM_AW-1:0]     addr_r, addr_nxt;
	logic                  ld_valid_r, ld_valid_nxt;
	logic [MEM_AW-1:0]     ld_addr_r, ld_addr_nxt;
	logic [DATA_W-1:0]     ld_data_r, ld_data_nxt;
	logic                  done_r, done_nxt;
	logic [5:0]            health_r, health_nxt;
	logic [15:0]           wafer_r, wafer_nxt;
	logic [4:0]            syn;
	logic                  par;
	logic                  single_bit_corrected;
	logic                  double_err;
	logic [CODE_W-1:0]     fixed;
	zone_t                 zone;

	always_comb begin
		syn                  = ham_syndrome(MEM_RDATA);
		par                  = ^MEM_RDATA;
		single_bit_corrected = par; // [R5]
		double_err           = !par && (syn != 5'h00); // [R5]
		fixed                = MEM_RDATA;
		if (par && (syn <= 5'(HAM_W))) begin
			fixed[syn] = !MEM_RDATA[syn]; // [R5]
		end
		if (addr_r >= RED_FIRST) begin
			zone = ZONE_RED; // [R3]
		end else if (addr_r >= YELLOW_FIRST) begin
			zone = ZONE_YELLOW; // [R3]
		end else begin
			zone = ZONE_GREEN; // [R3]
		end
	end

	always_comb begin
		ld_state_nxt = ld_state_r;
		rd_en_nxt    = 1'b0;
		addr_nxt     = addr_r;
		ld_valid_nxt = 1'b0;
		ld_addr_nxt  = ld_addr_r;
		ld_data_nxt  = ld_data_r;
		done_nxt     = done_r;
		health_nxt   = health_r;
		wafer_nxt    = wafer_r;
		unique case (ld_state_r)
			LD_START: begin
				addr_nxt     = GREEN_FIRST;
				rd_en_nxt    = 1'b1;
				ld_state_nxt = LD_ISSUE;
			end
			LD_ISSUE: begin
				ld_state_nxt = LD_CHECK;
			end
			LD_CHECK: begin
				ld_valid_nxt = 1'b1;
				ld_addr_nxt  = addr_r;
				ld_data_nxt  = ham_extract(fixed);
				unique case (zone)
					ZONE_RED: begin
						health_nxt[HB_RED_WARN-HB_GRN_ERR] = health_r[HB_RED_WARN-HB_GRN_ERR]
							| single_bit_corrected; // [R6] [R13]
						health_nxt[HB_RED_ERR-HB_GRN_ERR]  = health_r[HB_RED_ERR-HB_GRN_ERR]
							| double_err; // [R7] [R13]
					end
					ZONE_YELLOW: begin
						health_nxt[HB_YEL_WARN-HB_GRN_ERR] = health_r[HB_YEL_WARN-HB_GRN_ERR]
							| single_bit_corrected; // [R8] [R13]
						health_nxt[HB_YEL_ERR-HB_GRN_ERR]  = health_r[HB_YEL_ERR-HB_GRN_ERR]
							| double_err; // [R9] [R13]
					end
					default: begin
						health_nxt[HB_GRN_WARN-HB_GRN_ERR] = health_r[HB_GRN_WARN-HB_GRN_ERR]
							| single_bit_corrected; // [R10] [R13]
						health_nxt[0]                      = health_r[0] | double_err; // [R11] [R13]
					end
				endcase
				if (addr_r == WAFER_WORD) begin
					wafer_nxt = ham_extract(fixed);
				end
				if (addr_r == LAST_WORD) begin
					done_nxt     = 1'b1;
					ld_state_nxt = LD_DONE;
				end else begin
					addr_nxt     = addr_r + 1'b1;
					rd_en_nxt    = 1'b1;
					ld_state_nxt = LD_ISSUE;
				end
			end
			LD_DONE: begin
				ld_state_nxt = LD_DONE; // [R13]
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ld_state_r <= LD_START;
			rd_en_r    <= 1'b0;
			addr_r     <= '0;
			ld_valid_r <= 1'b0;
			ld_addr_r  <= '0;
			ld_data_r  <= '0;
			done_r     <= 1'b0;
			health_r   <= '0;
			wafer_r    <= REG_RESET_VAL;
		end else begin
			ld_state_r <= ld_state_nxt;
			rd_en_r    <= rd_en_nxt;
			addr_r     <= addr_nxt;
			ld_valid_r <= ld_valid_nxt;
			ld_addr_r  <= ld_addr_nxt;
			ld_data_r  <= ld_data_nxt;
			done_r     <= done_nxt;
			health_r   <= health_nxt;
			wafer_r    <= wafer_nxt;
		end
	end

	// register read port, read-only map
	logic        rvalid_r, rvalid_nxt;
	logic [15:0] rdata_r, rdata_nxt;

	always_comb begin
		rvalid_nxt = REG_RD;
		rdata_nxt  = rdata_r;
		if (REG_RD) begin
			rdata_nxt = REG_RESET_VAL;
			if (REG_MMD == MMD_VEND1 && REG_ADDR == OFS_WAFER_POS) begin
				rdata_nxt[WAFER_Y_MSB:WAFER_Y_LSB] = wafer_r[WAFER_Y_MSB:WAFER_Y_LSB]; // [R1]
				rdata_nxt[WAFER_X_MSB:WAFER_X_LSB] = wafer_r[WAFER_X_MSB:WAFER_X_LSB]; // [R2]
			end else if (REG_MMD == MMD_VEND1 && REG_ADDR == OFS_CFG_HEALTH) begin
				if (done_r) begin
					rdata_nxt[HB_RED_WARN:HB_GRN_ERR] = health_r; // [R6] [R7] [R8] [R9] [R10] [R11] [R13]
				end
			end else if (REG_MMD == MMD_VEND2 && REG_ADDR == OFS_SI_REV) begin
				rdata_nxt = {REV_MAJOR, REV_MINOR, REV_STAGE, REV_PATCH}; // [R12]
			end
		end
	end

	// no write strobe exists; memory is only ever read [R4]
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			rvalid_r <= 1'b0;
			rdata_r  <= REG_RESET_VAL;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign MEM_RD_EN  = rd_en_r;
	assign MEM_ADDR   = addr_r;
	assign LOAD_VALID = ld_valid_r;
	assign LOAD_ADDR  = ld_addr_r;
	assign LOAD_DATA  = ld_data_r;
	assign LOAD_DONE  = done_r;
	assign REG_RVALID = rvalid_r;
	assign REG_RDATA  = rdata_r;
endmodule

// file: logic/config_memory_health_pkg.sv
package config_memory_health_pkg;
	// register map (mmd number, address)
	localparam logic [4:0]  MMD_VEND1        = 5'h1e;
	localparam logic [4:0]  MMD_VEND2        = 5'h1f;
	localparam logic [15:0] OFS_WAFER_POS    = 16'h1004;
	localparam logic [15:0] OFS_CFG_HEALTH   = 16'h1005;
	localparam logic [15:0] OFS_SI_REV       = 16'h8000;
	localparam logic [15:0] REG_RESET_VAL    = 16'h0000;
	// wafer position fields
	localparam int          WAFER_Y_LSB      = 8;
	localparam int          WAFER_Y_MSB      = 14;
	localparam int          WAFER_X_LSB      = 0;
	localparam int          WAFER_X_MSB      = 6;
	// health bit positions
	localparam int          HB_RED_WARN      = 15;
	localparam int          HB_RED_ERR       = 14;
	localparam int          HB_YEL_WARN      = 13;
	localparam int          HB_YEL_ERR       = 12;
	localparam int          HB_GRN_WARN      = 11;
	localparam int          HB_GRN_ERR       = 10;
	// revision fields
	localparam int          REV_MAJOR_LSB    = 12;
	localparam int          REV_MINOR_LSB    = 8;
	localparam int          REV_STAGE_LSB    = 6;
	localparam int          REV_PATCH_LSB    = 0;
	// factory memory layout, word addresses
	localparam int          MEM_AW           = 8;
	localparam int          DATA_W           = 16;
	localparam int          HAM_W            = 21;
	localparam int          CODE_W           = 22;
	localparam logic [7:0]  GREEN_FIRST      = 8'h00;
	localparam logic [7:0]  YELLOW_FIRST     = 8'h10;
	localparam logic [7:0]  RED_FIRST        = 8'h20;
	localparam logic [7:0]  LAST_WORD        = 8'h3f;
	localparam logic [7:0]  WAFER_WORD       = 8'h00;
	// zone codes
	typedef enum logic [1:0] {
		ZONE_GREEN  = 2'h0,
		ZONE_YELLOW = 2'h1,
		ZONE_RED    = 2'h2
	} zone_t;
	// loader states, gray along the path
	typedef enum logic [1:0] {
		LD_START = 2'b00,
		LD_ISSUE = 2'b01,
		LD_CHECK = 2'b11,
		LD_DONE  = 2'b10
	} ld_state_t;
endpackage

// file: bench/nvm_ecc_health_chk.sv
`timescale 1ns/10ps
module nvm_ecc_health_chk #(
	parameter logic [3:0] REV_MAJOR = 4'h1,
	parameter logic [3:0] REV_MINOR = 4'h0,
	parameter logic [1:0] REV_STAGE = 2'h3,
	parameter logic [5:0] REV_PATCH = 6'h00
) (
	input wire logic        SYS_CLK,
	input wire logic        RST_N,
	input wire logic        MEM_RD_EN,
	input wire logic [7:0]  MEM_ADDR,
	input wire logic        LOAD_VALID,
	input wire logic [7:0]  LOAD_ADDR,
	input wire logic        LOAD_DONE,
	input wire logic        REG_RD,
	input wire logic [4:0]  REG_MMD,
	input wire logic [15:0] REG_ADDR,
	input wire logic        REG_RVALID,
	input wire logic [15:0] REG_RDATA
);
	import config_memory_health_pkg::*;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	wire wafer_q  = REG_RD && REG_MMD == MMD_VEND1 && REG_ADDR == OFS_WAFER_POS;
	wire health_q = REG_RD && REG_MMD == MMD_VEND1 && REG_ADDR == OFS_CFG_HEALTH;
	wire rev_q    = REG_RD && REG_MMD == MMD_VEND2 && REG_ADDR == OFS_SI_REV;
	chk_answer_next: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered next cycle");
	chk_answer_cause: assert property (REG_RVALID |-> $past(REG_RD))
		else $error("answer without request");
	chk_wafer_pad: assert property (wafer_q |=> !REG_RDATA[15] && !REG_RDATA[7])
		else $error("wafer pad bits set");
	chk_health_low: assert property (health_q |=> REG_RDATA[9:0] == 10'h000)
		else $error("health low bits set");
	chk_health_gate: assert property (health_q && !LOAD_DONE |=> REG_RDATA[15:10] == 6'h00)
		else $error("health flags shown before load done");
	chk_rev_word: assert property (rev_q |=> REG_RDATA == {REV_MAJOR, REV_MINOR, REV_STAGE, REV_PATCH})
		else $error("revision word wrong");
	chk_load_latency: assert property (MEM_RD_EN |-> ##2 LOAD_VALID && LOAD_ADDR == $past(MEM_ADDR, 2))
		else $error("load word late or misaddressed");
	chk_read_step: assert property (MEM_RD_EN && MEM_ADDR != LAST_WORD
		|=> !MEM_RD_EN ##1 MEM_RD_EN && MEM_ADDR == $past(MEM_ADDR, 2) + 8'h01)
		else $error("memory read sequence broken");
	chk_done_hold: assert property (LOAD_DONE |=> LOAD_DONE && !MEM_RD_EN)
		else $error("load repeated or done dropped");
	cover property (LOAD_VALID && LOAD_ADDR == LAST_WORD);
	cover property (LOAD_DONE && health_q);
	cover property (health_q ##1 REG_RDATA[15:10] != 6'h00);
endmodule
bind nvm_ecc_health nvm_ecc_health_chk #(.REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR), .REV_STAGE(REV_STAGE),
	.REV_PATCH(REV_PATCH)) chk_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .MEM_RD_EN(MEM_RD_EN),
	.MEM_ADDR(MEM_ADDR), .LOAD_VALID(LOAD_VALID), .LOAD_ADDR(LOAD_ADDR), .LOAD_DONE(LOAD_DONE), .REG_RD(REG_RD),
	.REG_MMD(REG_MMD), .REG_ADDR(REG_ADDR), .REG_RVALID(REG_RVALID), .REG_RDATA(REG_RDATA));

// file: bench/nvm_mem_model.sv
`timescale 1ns/10ps
module nvm_mem_model (
	input wire logic        clk,
	input wire logic        rd_en,
	input wire logic [7:0]  addr,
	output logic     [21:0] rdata
);
	logic [15:0] data [64];
	logic [21:0] flip [64];
	logic        hold_r = 1'b0;
	// hamming plus overall even parity
	function automatic logic [21:0] enc(input logic [15:0] d);
		logic [21:0] c;
		int          k;
		c = '0;
		k = 0;
		for (int j = 1; j < 22; j++) if ((j & (j - 1)) != 0) begin
			c[j] = d[k];
			k++;
		end
		for (int p = 1; p < 22; p *= 2) for (int j = 1; j < 22; j++) if ((j & p) != 0 && j != p) c[p] ^= c[j];
		c[0] = ^c;
		return c;
	endfunction
	// read only, no write port; lines toggle once hold runs out
	initial rdata = '0;
	always @(posedge clk) begin
		hold_r <= rd_en;
		if (rd_en) rdata <= enc(data[addr[5:0]]) ^ flip[addr[5:0]];
		else if (!hold_r) rdata <= ~rdata;
	end
endmodule

// file: bench/nvm_ecc_health_tb.sv
`timescale 1ns/10ps
module nvm_ecc_health_tb;
	import config_memory_health_pkg::*;
	logic        SYS_CLK = 1'b0, RST_N = 1'b0, REG_RD = 1'b0;
	logic [4:0]  REG_MMD = '0;
	logic [15:0] REG_ADDR = '0, LOAD_DATA, REG_RDATA;
	logic        MEM_RD_EN, LOAD_VALID, LOAD_DONE, REG_RVALID;
	logic [7:0]  MEM_ADDR, LOAD_ADDR;
	logic [21:0] MEM_RDATA;
	int          err_total = 0, checked = 0, seed = 21233;
	int          ek [64];
	logic [1:0]  zk [3];
	always #4 SYS_CLK = ~SYS_CLK;
	nvm_ecc_health nvm_ecc_health_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .MEM_RD_EN(MEM_RD_EN),
		.MEM_ADDR(MEM_ADDR), .MEM_RDATA(MEM_RDATA), .LOAD_VALID(LOAD_VALID), .LOAD_ADDR(LOAD_ADDR),
		.LOAD_DATA(LOAD_DATA), .LOAD_DONE(LOAD_DONE), .REG_RD(REG_RD), .REG_MMD(REG_MMD), .REG_ADDR(REG_ADDR),
		.REG_RVALID(REG_RVALID), .REG_RDATA(REG_RDATA));
	nvm_mem_model nvm_mem_model_inst (.clk(SYS_CLK), .rd_en(MEM_RD_EN), .addr(MEM_ADDR), .rdata(MEM_RDATA));
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function logic [15:0] exp_health();
		return {zk[2], zk[1], zk[0], 10'h000};
	endfunction
	task rd(input logic [4:0] m, input logic [15:0] a, input logic [15:0] exp);
		@(posedge SYS_CLK);
		REG_RD <= 1'b1;
		REG_MMD <= m;
		REG_ADDR <= a;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		#1;
		cmp({15'h0000, REG_RVALID}, 16'h0001);
		cmp(REG_RDATA, exp);
	endtask
	task do_reset();
		@(posedge SYS_CLK);
		RST_N <= 1'b0;
		repeat (16) @(posedge SYS_CLK);
		RST_N <= 1'b1;
	endtask
	// per zone: bit1 single error on first word, bit0 double error elsewhere
	task plant(input int r);
		int b, w;
		for (int i = 0; i < 64; i++) begin
			nvm_mem_model_inst.data[i] = 16'($random(seed));
			nvm_mem_model_inst.flip[i] = '0;
			ek[i] = 0;
		end
		for (int z = 0; z < 3; z++) begin
			zk[z] = (r == 0) ? 2'b00 : (r == 1) ? 2'b10 : (r == 2) ? 2'b01 : 2'($random(seed));
			b = {$random(seed)} % 22;
			w = 16 * z + 1 + {$random(seed)} % 15;
			if (zk[z][1]) nvm_mem_model_inst.flip[16 * z] = 22'h1 << b;
			if (zk[z][1]) ek[16 * z] = 1;
			if (zk[z][0]) nvm_mem_model_inst.flip[w] = (22'h1 << b) | (22'h1 << ((b + 1) % 22));
			if (zk[z][0]) ek[w] = 2;
		end
	endtask
	always @(negedge SYS_CLK) if (RST_N && LOAD_VALID === 1'b1 && ek[LOAD_ADDR[5:0]] != 2)
		cmp(LOAD_DATA, nvm_mem_model_inst.data[LOAD_ADDR[5:0]]);
	task wrap_up();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		err_total++;
		wrap_up();
	end
	initial begin
		for (int r = 0; r < 6; r++) begin
			plant(r);
			do_reset();
			if (r == 3) begin
				repeat (40) @(posedge SYS_CLK);
				rd(MMD_VEND1, OFS_CFG_HEALTH, 16'h0000);
				do_reset();
			end
			rd(MMD_VEND1, OFS_CFG_HEALTH, 16'h0000);
			cmp({15'h0000, LOAD_DONE}, 16'h0000);
			for (int i = 0; i < 300 && LOAD_DONE !== 1'b1; i++) @(posedge SYS_CLK);
			cmp({15'h0000, LOAD_DONE}, 16'h0001);
			rd(MMD_VEND1, OFS_WAFER_POS, nvm_mem_model_inst.data[0] & 16'h7f7f);
			rd(MMD_VEND1, OFS_CFG_HEALTH, exp_health());
			rd(MMD_VEND2, OFS_SI_REV, 16'h10c0);
			rd(MMD_VEND2, OFS_CFG_HEALTH, 16'h0000);
			rd(MMD_VEND1, 16'h2000 | 16'($random(seed)) & 16'h0fff, 16'h0000);
			repeat (20) @(posedge SYS_CLK);
			rd(MMD_VEND1, OFS_CFG_HEALTH, exp_health());
			$display("test %0d done", r);
		end
		wrap_up();
	end
endmodule
